// *** rtl/mrr_result_regs.sv ***
// Read-only result registers: channel 2 source voltage, channel 1 and 2 power ratio
// Assumes results arrive as one-cycle strobes from the engine on the same clock,
// and the serial management front end presents a byte address and takes read data.
//
// Overview of operation
// (R1) Channel 2 source voltage is an 11-bit unsigned field, top bit 20 V.
// (R2) Low five bits of the voltage low byte always read zero.
// (R3) Single-channel build: all channel 2 results read zero.
// (R4) Channel 1 power ratio: high byte 15h, low byte 16h, read-only, reset zero.
// (R5) Channel 1 power ratio updates on each new power calculation.
// (R6) Channel 2 power ratio: high byte 17h, low byte 18h, read-only, reset zero.
// (R7) Dual-channel build holds the latest channel 2 power ratio.
// (R8) Host writes to these locations are ignored without error.
`default_nettype none
`include "mrr_defines.svh"
module mrr_result_regs #(
  parameter bit DUAL_CHANNEL = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Results from the measurement engine
  input wire logic ch1_pwr_valid,
  input wire mrr_pkg::mrr_pwr_t ch1_pwr,
  input wire logic ch2_pwr_valid,
  input wire mrr_pkg::mrr_pwr_t ch2_pwr,
  input wire logic ch2_volt_valid,
  input wire mrr_pkg::mrr_volt_t ch2_volt,
  // Register port from the serial front end
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire mrr_pkg::mrr_addr_t reg_addr,
  input wire mrr_pkg::mrr_byte_t reg_wdata,
  output mrr_pkg::mrr_byte_t reg_rdata,
  output logic reg_rvalid
);
  import mrr_pkg::*;

  mrr_pwr_t ch1_pwr_r;
  mrr_pwr_t ch2_pwr_r;
  mrr_volt_t ch2_volt_r;
  mrr_byte_t rdata_nxt;
  mrr_byte_t ch2v_hi;
  mrr_byte_t ch2v_lo;
  mrr_byte_t ch2p_hi;
  mrr_byte_t ch2p_lo;
  logic unused_wr;

  // Write path carries no state: results belong to the engine alone
  assign unused_wr = reg_wr ^ (^reg_wdata); // [R8]

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ch1_pwr_r <= `MRR_PWR_RST; // [R4]
      ch2_pwr_r <= `MRR_PWR_RST; // [R6]
      ch2_volt_r <= `MRR_VOLT_RST;
    end
    else
    begin
      if (ch1_pwr_valid)
        ch1_pwr_r <= ch1_pwr; // [R5]
      if (ch2_pwr_valid && DUAL_CHANNEL)
        ch2_pwr_r <= ch2_pwr; // [R7]
      if (ch2_volt_valid && DUAL_CHANNEL)
        ch2_volt_r <= ch2_volt; // [R1]
    end
  end

  // Left-justified voltage; the spare low bits are hard zero
  assign ch2v_hi = DUAL_CHANNEL ? ch2_volt_r[10:3] : 8'h00; // [R1] [R3]
  assign ch2v_lo = DUAL_CHANNEL ? {ch2_volt_r[2:0], 5'h00} : 8'h00; // [R2] [R3]
  assign ch2p_hi = DUAL_CHANNEL ? ch2_pwr_r[15:8] : 8'h00; // [R3]
  assign ch2p_lo = DUAL_CHANNEL ? ch2_pwr_r[7:0] : 8'h00; // [R3]

  always_comb
  begin
    unique case (reg_addr)
      `MRR_CH2V_HI_ADDR: rdata_nxt = ch2v_hi;
      `MRR_CH2V_LO_ADDR: rdata_nxt = ch2v_lo;
      `MRR_CH1P_HI_ADDR: rdata_nxt = ch1_pwr_r[15:8]; // [R4]
      `MRR_CH1P_LO_ADDR: rdata_nxt = ch1_pwr_r[7:0]; // [R4]
      `MRR_CH2P_HI_ADDR: rdata_nxt = ch2p_hi; // [R6]
      `MRR_CH2P_LO_ADDR: rdata_nxt = ch2p_lo; // [R6]
      default: rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_nxt;
    end
  end

  // Checks
  sequence ch1_load_s;
    ch1_pwr_valid ##1 reg_rd && reg_addr == `MRR_CH1P_LO_ADDR;
  endsequence

  ch1_update_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    ch1_pwr_valid |=> ch1_pwr_r == $past(ch1_pwr))
    else $error("channel 1 power ratio not loaded");
  ch1_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    ch1_load_s |=> reg_rvalid && reg_rdata == $past(ch1_pwr, 2) % 256)
    else $error("channel 1 low byte read wrong");
  volt_low_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    reg_rd && reg_addr == `MRR_CH2V_LO_ADDR |=> reg_rdata[4:0] == 5'h00)
    else $error("voltage low bits not zero");
  volt_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    !ch2_volt_valid |=> $stable(ch2_volt_r))
    else $error("voltage result changed without sample");
  ch2_single_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    !DUAL_CHANNEL && reg_rd && reg_addr inside {[8'h13:8'h14], [8'h17:8'h18]}
    |=> reg_rdata == 8'h00)
    else $error("channel 2 not zero on single build");
  ch2_update_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    DUAL_CHANNEL && ch2_pwr_valid |=> ch2_pwr_r == $past(ch2_pwr))
    else $error("channel 2 power ratio not loaded");
  ch2_read_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    reg_rd && reg_addr == `MRR_CH2P_HI_ADDR |=> reg_rdata == $past(ch2p_hi))
    else $error("channel 2 high byte read wrong");
  write_ignore_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
    reg_wr && !ch1_pwr_valid |=> $stable(ch1_pwr_r))
    else $error("host write altered result");

  // Further checks on the read path and the result holders
  // Expectations use the stored results, not the muxed bytes, so a wrong select shows up
  // No snapshot of hi and lo bytes: each byte read is checked on its own

  sequence volt_load_s;
    ch2_volt_valid && DUAL_CHANNEL;
  endsequence

  sequence volt_hi_read_s;
    DUAL_CHANNEL && reg_rd && reg_addr == `MRR_CH2V_HI_ADDR;
  endsequence

  sequence volt_lo_read_s;
    DUAL_CHANNEL && reg_rd && reg_addr == `MRR_CH2V_LO_ADDR;
  endsequence

  sequence ch1_hi_read_s;
    reg_rd && reg_addr == `MRR_CH1P_HI_ADDR;
  endsequence

  sequence ch2_lo_read_s;
    DUAL_CHANNEL && reg_rd && reg_addr == `MRR_CH2P_LO_ADDR;
  endsequence

  sequence unmapped_read_s;
    reg_rd && !(reg_addr inside {[`MRR_CH2V_HI_ADDR:`MRR_CH2P_LO_ADDR]});
  endsequence

  sequence host_write_s;
    reg_wr && !reg_rd;
  endsequence

  rvalid_follow_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    reg_rd |=> reg_rvalid)
    else $error("read answer missing");

  rvalid_idle_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    !reg_rd |=> !reg_rvalid)
    else $error("read answer without request");

  rdata_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without read");

  unmapped_zero_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    unmapped_read_s |=> reg_rdata == 8'h00)
    else $error("unmapped address not zero");

  ch1_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
    !ch1_pwr_valid |=> $stable(ch1_pwr_r))
    else $error("channel 1 result changed without update");

  ch2_hold_a: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
    !ch2_pwr_valid |=> $stable(ch2_pwr_r))
    else $error("channel 2 result changed without update");

  volt_update_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    volt_load_s |=> ch2_volt_r == $past(ch2_volt))
    else $error("voltage result not loaded");

  volt_hi_a: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
    volt_hi_read_s |=> reg_rdata == $past(ch2_volt_r[10:3]))
    else $error("voltage high byte read wrong");

  volt_lo_a: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
    volt_lo_read_s |=> reg_rdata[7:5] == $past(ch2_volt_r[2:0]))
    else $error("voltage low byte read wrong");

  ch1_hi_a: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
    ch1_hi_read_s |=> reg_rdata == $past(ch1_pwr_r[15:8]))
    else $error("channel 1 high byte read wrong");

  ch2_lo_a: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
    ch2_lo_read_s |=> reg_rdata == $past(ch2_pwr_r[7:0]))
    else $error("channel 2 low byte read wrong");

  single_clear_a: assert property (@(posedge clock) disable iff (!rst_n) // [R3]
    !DUAL_CHANNEL |-> ch2_pwr_r == `MRR_PWR_RST && ch2_volt_r == `MRR_VOLT_RST)
    else $error("channel 2 holds data on single build");

  write_ch2_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
    reg_wr && !ch2_pwr_valid |=> $stable(ch2_pwr_r))
    else $error("host write altered channel 2 result");

  write_volt_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
    reg_wr && !ch2_volt_valid |=> $stable(ch2_volt_r))
    else $error("host write altered voltage result");

  write_quiet_a: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
    host_write_s |=> !reg_rvalid)
    else $error("host write produced a read answer");
endmodule
`default_nettype wire

// *** inc/mrr_defines.svh ***
// Constants for the measurement result register bank
// Assumes byte-wide register addresses on the management port
`ifndef MRR_DEFINES_SVH
`define MRR_DEFINES_SVH
`define MRR_CH2V_HI_ADDR 8'h13
`define MRR_CH2V_LO_ADDR 8'h14
`define MRR_CH1P_HI_ADDR 8'h15
`define MRR_CH1P_LO_ADDR 8'h16
`define MRR_CH2P_HI_ADDR 8'h17
`define MRR_CH2P_LO_ADDR 8'h18
`define MRR_VOLT_W 11
`define MRR_VOLT_LSB 5
`define MRR_PWR_RST 16'h0000
`define MRR_VOLT_RST 11'h000
`endif

// *** inc/mrr_pkg.sv ***
// Types for the measurement result register bank
// Assumes mrr_defines.svh sits on the include path
`default_nettype none
`include "mrr_defines.svh"
package mrr_pkg;
  typedef logic [7:0] mrr_addr_t;
  typedef logic [7:0] mrr_byte_t;
  typedef logic [15:0] mrr_pwr_t;
  typedef logic [`MRR_VOLT_W-1:0] mrr_volt_t;
endpackage
`default_nettype wire

// *** bench/mrr_host.sv ***
// Host model: byte reads and writes on the result bank's register port
// Assumes one shared clock; drives at the falling edge
`default_nettype none
module mrr_host (
  // Clock
  input wire logic clock,
  // Register port
  output logic reg_rd,
  output logic reg_wr,
  output mrr_pkg::mrr_addr_t reg_addr,
  output mrr_pkg::mrr_byte_t reg_wdata,
  input wire mrr_pkg::mrr_byte_t rdata_a,
  input wire mrr_pkg::mrr_byte_t rdata_b,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ns;
  import mrr_pkg::*;
  initial
  begin
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Answer is due one cycle later; a late answer yields unknowns in da, while db is taken as it stands
  task automatic rd(input mrr_addr_t a, output mrr_byte_t da, output mrr_byte_t db);
    @(negedge clock);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clock);
    reg_rd = 1'b0;
    reg_addr = ~a;
    da = (reg_rvalid === 1'b1) ? rdata_a : 8'hXX;
    db = rdata_b;
  endtask
  task automatic wr(input mrr_addr_t a, input mrr_byte_t d);
    @(negedge clock);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire

// *** bench/testbench.sv ***
// Testbench: dual and single builds of the result bank read side by side
// Assumes assertions live in the design body
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import mrr_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic p1_v = 1'b0, p2_v = 1'b0, v2_v = 1'b0, rd, wr, rv;
  mrr_pwr_t p1 = 16'h0000, p2 = 16'h0000;
  mrr_volt_t v2 = 11'h000;
  mrr_addr_t addr;
  mrr_byte_t wd, da_w, db_w, da, db;
  int n_errors = 0;
  int comparisons = 0;
  always #25 clock = ~clock;
  mrr_result_regs mrr_result_regs_inst (.clock(clock), .rst_n(rst_n), .ch1_pwr_valid(p1_v),
    .ch1_pwr(p1), .ch2_pwr_valid(p2_v), .ch2_pwr(p2), .ch2_volt_valid(v2_v), .ch2_volt(v2),
    .reg_rd(rd), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd), .reg_rdata(da_w), .reg_rvalid(rv));
  mrr_result_regs #(.DUAL_CHANNEL(1'b0)) mrr_result_regs_inst1 (.clock(clock), .rst_n(rst_n),
    .ch1_pwr_valid(p1_v), .ch1_pwr(p1), .ch2_pwr_valid(p2_v), .ch2_pwr(p2),
    .ch2_volt_valid(v2_v), .ch2_volt(v2), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
    .reg_wdata(wd), .reg_rdata(db_w), .reg_rvalid());
  mrr_host mrr_host_inst (.clock(clock), .reg_rd(rd), .reg_wr(wr), .reg_addr(addr),
    .reg_wdata(wd), .rdata_a(da_w), .rdata_b(db_w), .reg_rvalid(rv));
  task automatic chk(input string nm, input mrr_byte_t e, input mrr_byte_t g);
    comparisons++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic rd_chk(input mrr_addr_t a, input mrr_byte_t ea, input mrr_byte_t eb);
    mrr_host_inst.rd(a, da, db);
    chk("dual byte", ea, da);
    chk("single byte", eb, db);
  endtask
  task automatic t_ch1();
    rd_chk(8'h15, 8'h00, 8'h00);
    @(negedge clock);
    {p1_v, p1} = {1'b1, 16'hA5C3};
    @(negedge clock);
    {p1_v, p1} = {1'b0, 16'h5A3C};
    rd_chk(8'h15, 8'hA5, 8'hA5);
    rd_chk(8'h16, 8'hC3, 8'hC3);
    $display("channel 1 test done");
  endtask
  task automatic t_ch2();
    rd_chk(8'h18, 8'h00, 8'h00);
    rd_chk(8'h13, 8'h00, 8'h00);
    @(negedge clock);
    {p2_v, v2_v, p2, v2} = {2'b11, 16'h8001, 11'h5A3};
    @(negedge clock);
    {p2_v, v2_v, p2, v2} = {2'b00, 16'h7FFE, 11'h000};
    rd_chk(8'h17, 8'h80, 8'h00);
    rd_chk(8'h18, 8'h01, 8'h00);
    rd_chk(8'h13, 8'hB4, 8'h00);
    rd_chk(8'h14, 8'h60, 8'h00);
    $display("channel 2 test done");
  endtask
  task automatic t_write();
    mrr_host_inst.wr(8'h15, 8'h00);
    mrr_host_inst.wr(8'h14, 8'hFF);
    rd_chk(8'h15, 8'hA5, 8'hA5);
    rd_chk(8'h14, 8'h60, 8'h00);
    rd_chk(8'h20, 8'h00, 8'h00);
    $display("write test done");
  endtask
  task automatic print_verdict();
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (2) @(negedge clock);
    rst_n = 1'b1;
    t_ch1();
    t_ch2();
    t_write();
    print_verdict();
  end
endmodule
`default_nettype wire
